// *** inc/tbc_pkg.sv ***
// How it works
// - frames queued via data FIFO, multi-buffer packets
// - each buffer led by two command words
// - packet bounds from command segment bits only
// - command tag copied into status word
// - tag mismatch within packet sets error
// - length field is packet size in bytes
// - received byte count mismatch sets error
// - start offset skips bytes within eight words
// - later buffers start anywhere, bytes concatenated
// - surplus end words accepted when enabled
// - padding to end alignment dropped
// - completion flag when buffer loaded
// - status word written after each transmission unless status FIFO full
// - status level flag at programmed count
// - overfilling data FIFO sets error
// - two 16-bit writes form one word
// - commands, offsets, padding take no FIFO space
// - alignment code 00/01/10 = 4/16/32 bytes
// - command A bit 31 raises loaded flag
// - command B must repeat, mismatch sets error
package tbc_pkg;
  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA_PORT = 8'h00; // 16-bit halves, low then high
  localparam logic [7:0] ADDR_SPACE_INFO = 8'h04; // tx_fifo_space_info
  localparam logic [7:0] ADDR_STATUS = 8'h08; // status pop on read
  localparam logic [7:0] ADDR_FLAGS = 8'h0C; // write one to clear
  localparam logic [7:0] ADDR_CTRL = 8'h10; // control
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100; // level 1, all off
  localparam int FLAG_ERR_BIT = 0; // tx_error_flag
  localparam int FLAG_LOADED_BIT = 1; // buffer_loaded_flag
  localparam int FLAG_LEVEL_BIT = 2; // status level reached
  localparam int CTRL_PAD_EN_BIT = 0; // accept end padding
  localparam int CTRL_LVL_EN_BIT = 1; // status level enable
  localparam int CTRL_LVL_LSB = 8; // status level field
  // --------------------------------------------------------------
  // sizes and codes
  // --------------------------------------------------------------
  localparam int DATA_DEPTH = 64; // data FIFO words
  localparam int STAT_DEPTH = 8; // status FIFO words
  localparam int INFO_DEPTH = 4; // packets awaiting send
  localparam logic [1:0] ALIGN_4 = 2'h0; // end alignment codes
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0; // axi responses
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // --------------------------------------------------------------
  // command, status and stream carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic ioc; logic [4:0] rsvd0; logic [1:0] end_align; logic [2:0] rsvd1;
    logic [4:0] start_off; logic [1:0] rsvd2; logic first_seg; logic last_seg;
    logic rsvd3; logic [10:0] buf_size;
  } tbc_cmd_a_t;
  typedef struct packed {
    logic [15:0] tag; logic [4:0] rsvd; logic [10:0] pkt_len;
  } tbc_cmd_b_t;
  typedef struct packed {
    logic [15:0] tag; logic err; logic [3:0] rsvd; logic [10:0] pkt_len;
  } tbc_status_t;
  typedef struct packed {
    logic last; logic [2:0] nbytes; logic [31:0] data;
  } tbc_word_t;
  typedef enum logic [2:0] {
    ST_CMD_A = 3'b001, ST_CMD_B = 3'b010, ST_DATA = 3'b100
  } tbc_state_t;
endpackage

// *** core/tbc_tx_front.sv ***
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module tbc_tx_front (
  input wire logic i_ref_clk, // 200 MHz clock
  input wire logic i_sys_rst, // sync reset, high
  input wire logic i_s_axi_awvalid, // write address valid
  output logic o_s_axi_awready, // write address ready
  input wire logic [7:0] i_s_axi_awaddr, // write address
  input wire logic i_s_axi_wvalid, // write data valid
  output logic o_s_axi_wready, // write data ready
  input wire logic [31:0] i_s_axi_wdata, // write data
  input wire logic [3:0] i_s_axi_wstrb, // byte strobes
  output logic o_s_axi_bvalid, // write response valid
  input wire logic i_s_axi_bready, // write response ready
  output logic [1:0] o_s_axi_bresp, // write response
  input wire logic i_s_axi_arvalid, // read address valid
  output logic o_s_axi_arready, // read address ready
  input wire logic [7:0] i_s_axi_araddr, // read address
  output logic o_s_axi_rvalid, // read data valid
  input wire logic i_s_axi_rready, // read data ready
  output logic [31:0] o_s_axi_rdata, // read data
  output logic [1:0] o_s_axi_rresp, // read response
  output tbc_pkg::tbc_word_t o_tx_word, // packed word to mac
  output logic o_tx_valid, // word valid
  input wire logic i_tx_ready, // mac takes word
  input wire logic i_tx_done, // one packet sent, pulse
  input wire logic i_tx_fail, // sent with failure
  output logic o_tx_error_flag, // sticky error
  output logic o_buffer_loaded_flag, // sticky completion
  output logic o_status_level_flag // status count reached
);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // append masked bytes of a word above the held bytes
  function automatic logic [58:0] pack_bytes(input logic [23:0] acc, input logic [1:0] accn,
                                             input logic [31:0] w, input logic [3:0] m);
    logic [55:0] buf_v;
    logic [2:0] n;
    buf_v = {32'h0000_0000, acc};
    n = {1'b0, accn};
    for (int b = 0; b < 4; b++) begin
      if (m[b]) begin
        buf_v[8*n +: 8] = w[8*b +: 8];
        n = n + 3'h1;
      end
    end
    return {n, buf_v};
  endfunction
  // count of kept bytes in a mask
  function automatic logic [2:0] ones(input logic [3:0] m);
    return 3'({2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]});
  endfunction

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  tbc_pkg::tbc_state_t state_r; // command/data walker
  tbc_pkg::tbc_cmd_a_t cmd_a_r; // current command a
  tbc_pkg::tbc_cmd_b_t cmd_b_r; // command b of packet
  tbc_pkg::tbc_word_t mem_r [tbc_pkg::DATA_DEPTH]; // data FIFO
  tbc_pkg::tbc_status_t stat_r [tbc_pkg::STAT_DEPTH]; // status FIFO
  tbc_pkg::tbc_cmd_b_t info_r [tbc_pkg::INFO_DEPTH]; // packets waiting
  logic info_err_r [tbc_pkg::INFO_DEPTH]; // per packet error
  logic [5:0] wp_r, rp_r; // data pointers
  logic [6:0] cnt_r; // data words held
  logic [2:0] swp_r, srp_r; // status pointers
  logic [3:0] scnt_r; // status words held
  logic [1:0] iwp_r, irp_r; // info pointers
  logic [2:0] icnt_r; // info entries
  logic aw_got_r, w_got_r; // write halves latched
  logic [7:0] awaddr_r; // latched address
  logic [31:0] wdata_r; // latched data
  logic [3:0] wstrb_r; // latched strobes
  logic [31:0] ctrl_r; // control register
  logic half_r; // low half held
  logic [15:0] lo_r; // low half
  logic word_v; // assembled word strobe
  logic [31:0] word; // assembled word
  logic [11:0] pos_r; // byte position in buffer
  logic [11:0] dend_r; // end of payload bytes
  logic [11:0] bend_r; // end incl. padding
  logic [11:0] pkt_bytes_r; // running packet count
  logic [23:0] acc_r; // held partial bytes
  logic [1:0] accn_r; // held byte count
  logic flush_r; // final partial word due
  logic pkt_err_r; // error within packet
  logic wr_fire, rd_fire; // bus events
  logic push; // data FIFO write
  tbc_pkg::tbc_word_t push_w; // word to write
  logic pop; // data FIFO read into output
  logic [3:0] mask; // payload bytes of word
  logic [58:0] pk; // packer result
  logic [2:0] pkn; // packer byte count
  logic data_end, buf_end; // payload / buffer end word
  logic set_err, set_loaded, pkt_end; // events
  logic [11:0] align_b; // alignment in bytes
  logic [11:0] raw_end; // offset plus size

  // --------------------------------------------------------------
  // axi4-lite write channel
  // --------------------------------------------------------------
  assign wr_fire = aw_got_r && w_got_r && !o_s_axi_bvalid;
  // address and data taken in either order
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      aw_got_r <= 1'b0; w_got_r <= 1'b0; awaddr_r <= 8'h00; wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0; o_s_axi_awready <= 1'b0; o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0; o_s_axi_bresp <= tbc_pkg::RESP_OKAY;
    end else begin
      o_s_axi_awready <= !aw_got_r && !(i_s_axi_awvalid && o_s_axi_awready);
      o_s_axi_wready <= !w_got_r && !(i_s_axi_wvalid && o_s_axi_wready);
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_got_r <= 1'b1; awaddr_r <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_got_r <= 1'b1; wdata_r <= i_s_axi_wdata; wstrb_r <= i_s_axi_wstrb;
      end
      if (wr_fire) begin // response after both
        aw_got_r <= 1'b0; w_got_r <= 1'b0; o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= (awaddr_r == tbc_pkg::ADDR_DATA_PORT || awaddr_r == tbc_pkg::ADDR_FLAGS ||
                          awaddr_r == tbc_pkg::ADDR_CTRL) ? tbc_pkg::RESP_OKAY : tbc_pkg::RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register, byte lanes honoured
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl_r <= tbc_pkg::CTRL_RESET;
    end else if (wr_fire && awaddr_r == tbc_pkg::ADDR_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_r[b]) ctrl_r[8*b +: 8] <= wdata_r[8*b +: 8];
      end
    end
  end

  // --------------------------------------------------------------
  // 16-bit halves into words
  // --------------------------------------------------------------
  // low half first, then high half completes the word
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      half_r <= 1'b0; lo_r <= 16'h0000; word_v <= 1'b0; word <= 32'h0000_0000;
    end else begin
      word_v <= 1'b0;
      if (wr_fire && awaddr_r == tbc_pkg::ADDR_DATA_PORT && wstrb_r[1:0] == 2'h3) begin
        if (!half_r) begin
          lo_r <= wdata_r[15:0]; half_r <= 1'b1;
        end else begin
          word <= {wdata_r[15:0], lo_r}; word_v <= 1'b1; half_r <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // buffer walker
  // --------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      mask[b] = (pos_r + 12'(b) >= 12'(cmd_a_r.start_off)) && (pos_r + 12'(b) < dend_r);
    end
    pk = pack_bytes(acc_r, accn_r, word, mask);
    pkn = pk[58:56];
    data_end = cmd_a_r.last_seg && (pos_r < dend_r) && (pos_r + 12'h004 >= dend_r);
    buf_end = (pos_r + 12'h004 >= bend_r);
    case (word[25:24])
      tbc_pkg::ALIGN_16: align_b = 12'h010;
      tbc_pkg::ALIGN_32: align_b = 12'h020;
      default: align_b = 12'h004;
    endcase
    if (!ctrl_r[tbc_pkg::CTRL_PAD_EN_BIT]) align_b = 12'h004;
    raw_end = 12'(word[20:16]) + 12'(word[10:0]);
  end

  // push one word per payload word at most; final partial word next cycle
  always_comb begin
    push = 1'b0;
    push_w = '0;
    if (flush_r) begin
      push = 1'b1;
      push_w = '{last: 1'b1, nbytes: {1'b0, accn_r}, data: {8'h00, acc_r}};
    end else if (word_v && state_r == tbc_pkg::ST_DATA && pkn >= 3'h4) begin
      push = 1'b1;
      push_w = '{last: data_end && pkn == 3'h4, nbytes: 3'h4, data: pk[31:0]};
    end
  end

  assign set_err = (push && cnt_r == 7'(tbc_pkg::DATA_DEPTH))
    || (word_v && state_r == tbc_pkg::ST_CMD_B && !cmd_a_r.first_seg && word != cmd_b_r)
    || (pkt_end && pkt_bytes_r + 12'(ones(mask)) != 12'(cmd_b_r.pkt_len));
  assign pkt_end = word_v && state_r == tbc_pkg::ST_DATA && buf_end && cmd_a_r.last_seg;
  assign set_loaded = word_v && state_r == tbc_pkg::ST_DATA && buf_end && cmd_a_r.ioc;

  // command a, command b, then payload words
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_r <= tbc_pkg::ST_CMD_A; cmd_a_r <= '0; cmd_b_r <= '0; pos_r <= 12'h000;
      dend_r <= 12'h000; bend_r <= 12'h000; pkt_bytes_r <= 12'h000; acc_r <= 24'h000000;
      accn_r <= 2'h0; flush_r <= 1'b0; pkt_err_r <= 1'b0;
    end else begin
      flush_r <= 1'b0;
      if (flush_r) accn_r <= 2'h0;
      if (word_v) begin
        case (state_r)
          tbc_pkg::ST_CMD_A: begin
            cmd_a_r <= word; pos_r <= 12'h000;
            dend_r <= raw_end;
            bend_r <= (raw_end + align_b - 12'h001) & ~(align_b - 12'h001);
            state_r <= tbc_pkg::ST_CMD_B;
          end
          tbc_pkg::ST_CMD_B: begin
            if (cmd_a_r.first_seg) begin
              cmd_b_r <= word; pkt_bytes_r <= 12'h000; pkt_err_r <= 1'b0;
            end else if (word != cmd_b_r) begin
              pkt_err_r <= 1'b1;
            end
            state_r <= (dend_r == 12'h000) ? tbc_pkg::ST_CMD_A : tbc_pkg::ST_DATA;
          end
          tbc_pkg::ST_DATA: begin
            pos_r <= pos_r + 12'h004;
            pkt_bytes_r <= pkt_bytes_r + 12'(ones(mask));
            if (pkn >= 3'h4) begin
              acc_r <= pk[55:32]; accn_r <= 2'(pkn - 3'h4);
            end else begin
              acc_r <= pk[23:0]; accn_r <= pkn[1:0];
            end
            if (data_end && pkn != 3'h4 && pkn != 3'h0) flush_r <= 1'b1;
            if (set_err) pkt_err_r <= 1'b1;
            if (buf_end) begin
              state_r <= tbc_pkg::ST_CMD_A;
              if (cmd_a_r.last_seg) pkt_bytes_r <= 12'h000;
            end
          end
          default: state_r <= tbc_pkg::ST_CMD_A;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // data FIFO and output stage
  // --------------------------------------------------------------
  assign pop = (!o_tx_valid || i_tx_ready) && cnt_r != 7'h00;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wp_r <= 6'h00; rp_r <= 6'h00; cnt_r <= 7'h00; o_tx_valid <= 1'b0; o_tx_word <= '0;
    end else begin
      if (push && cnt_r != 7'(tbc_pkg::DATA_DEPTH)) begin
        mem_r[wp_r] <= push_w; wp_r <= wp_r + 6'h01;
      end
      if (pop) begin
        o_tx_word <= mem_r[rp_r]; rp_r <= rp_r + 6'h01; o_tx_valid <= 1'b1;
      end else if (i_tx_ready) begin
        o_tx_valid <= 1'b0;
      end
      cnt_r <= cnt_r + 7'(push && cnt_r != 7'(tbc_pkg::DATA_DEPTH)) - 7'(pop);
    end
  end

  // --------------------------------------------------------------
  // packet info and status FIFO
  // --------------------------------------------------------------
  // status written per finished transmission, good or failed
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      iwp_r <= 2'h0; irp_r <= 2'h0; icnt_r <= 3'h0; swp_r <= 3'h0; srp_r <= 3'h0; scnt_r <= 4'h0;
    end else begin
      if (pkt_end && icnt_r != 3'(tbc_pkg::INFO_DEPTH)) begin
        info_r[iwp_r] <= cmd_b_r; info_err_r[iwp_r] <= pkt_err_r | set_err; iwp_r <= iwp_r + 2'h1;
      end
      if (i_tx_done && scnt_r != 4'(tbc_pkg::STAT_DEPTH)) begin
        stat_r[swp_r] <= '{tag: info_r[irp_r].tag, err: i_tx_fail | info_err_r[irp_r],
                           rsvd: 4'h0, pkt_len: info_r[irp_r].pkt_len};
        swp_r <= swp_r + 3'h1;
      end
      if (i_tx_done && icnt_r != 3'h0) irp_r <= irp_r + 2'h1;
      if (rd_fire && i_s_axi_araddr == tbc_pkg::ADDR_STATUS && scnt_r != 4'h0) srp_r <= srp_r + 3'h1;
      icnt_r <= icnt_r + 3'(pkt_end && icnt_r != 3'(tbc_pkg::INFO_DEPTH)) - 3'(i_tx_done && icnt_r != 3'h0);
      scnt_r <= scnt_r + 4'(i_tx_done && scnt_r != 4'(tbc_pkg::STAT_DEPTH))
        - 4'(rd_fire && i_s_axi_araddr == tbc_pkg::ADDR_STATUS && scnt_r != 4'h0);
    end
  end

  // --------------------------------------------------------------
  // flags
  // --------------------------------------------------------------
  // error and loaded flags sticky, set beats write-one-to-clear; level flag follows count
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_tx_error_flag <= 1'b0; o_buffer_loaded_flag <= 1'b0; o_status_level_flag <= 1'b0;
    end else begin
      if (set_err) o_tx_error_flag <= 1'b1;
      else if (wr_fire && awaddr_r == tbc_pkg::ADDR_FLAGS && wdata_r[tbc_pkg::FLAG_ERR_BIT])
        o_tx_error_flag <= 1'b0;
      if (set_loaded) o_buffer_loaded_flag <= 1'b1;
      else if (wr_fire && awaddr_r == tbc_pkg::ADDR_FLAGS && wdata_r[tbc_pkg::FLAG_LOADED_BIT])
        o_buffer_loaded_flag <= 1'b0;
      o_status_level_flag <= ctrl_r[tbc_pkg::CTRL_LVL_EN_BIT]
        && {4'h0, scnt_r} >= ctrl_r[tbc_pkg::CTRL_LVL_LSB +: 8] && ctrl_r[tbc_pkg::CTRL_LVL_LSB +: 8] != 8'h00;
    end
  end

  // --------------------------------------------------------------
  // axi4-lite read channel
  // --------------------------------------------------------------
  assign rd_fire = i_s_axi_arvalid && o_s_axi_arready;
  // one read at a time; status read pops one entry
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_s_axi_arready <= 1'b0; o_s_axi_rvalid <= 1'b0; o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= tbc_pkg::RESP_OKAY;
    end else begin
      o_s_axi_arready <= !o_s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= tbc_pkg::RESP_OKAY;
        case (i_s_axi_araddr)
          tbc_pkg::ADDR_SPACE_INFO:
            o_s_axi_rdata <= {12'h000, scnt_r, 7'h00, 7'(tbc_pkg::DATA_DEPTH) - cnt_r, 2'h0};
          tbc_pkg::ADDR_STATUS: o_s_axi_rdata <= (scnt_r != 4'h0) ? stat_r[srp_r] : 32'h0000_0000;
          tbc_pkg::ADDR_FLAGS:
            o_s_axi_rdata <= {29'h0, o_status_level_flag, o_buffer_loaded_flag, o_tx_error_flag};
          tbc_pkg::ADDR_CTRL: o_s_axi_rdata <= ctrl_r;
          tbc_pkg::ADDR_DATA_PORT: o_s_axi_rdata <= 32'h0000_0000;
          default: begin
            o_s_axi_rdata <= 32'h0000_0000; o_s_axi_rresp <= tbc_pkg::RESP_SLVERR;
          end
        endcase
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// *** verif/tbc_tx_front_asserts.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// bus and stream checks at the block's pins
// ------------------------------------------------------------
module tbc_tx_front_asserts (
  input wire logic i_ref_clk, // clock
  input wire logic i_sys_rst, // sync reset
  input wire logic o_s_axi_awready, // aw ready
  input wire logic o_s_axi_bvalid, // b valid
  input wire logic i_s_axi_arvalid, // ar valid
  input wire logic o_s_axi_arready, // ar ready
  input wire logic o_s_axi_rvalid, // r valid
  input wire tbc_pkg::tbc_word_t o_tx_word, // mac word
  input wire logic o_tx_valid, // word valid
  input wire logic i_tx_ready, // word taken
  input wire logic o_tx_error_flag, // error flag
  input wire logic o_buffer_loaded_flag, // loaded flag
  input wire logic o_status_level_flag // level flag
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // a stalled word holds still
  a_word_held: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_word))
    else $error("word changed while stalled");
  a_nbytes_range: assert property (o_tx_valid |-> o_tx_word.nbytes inside {[3'h1:3'h4]})
    else $error("byte count out of range");
  // only the closing word may be partial
  a_mid_full: assert property (o_tx_valid && !o_tx_word.last |-> o_tx_word.nbytes == 3'h4)
    else $error("partial word before packet end");
  // error and loaded flags drop only through a register write
  a_err_sticky: assert property (!$past(i_sys_rst) && $fell(o_tx_error_flag) |-> ##[0:2] o_s_axi_bvalid)
    else $error("error flag dropped without write");
  a_loaded_sticky: assert property (!$past(i_sys_rst) && $fell(o_buffer_loaded_flag)
    |-> ##[0:2] o_s_axi_bvalid)
    else $error("loaded flag dropped without write");
  a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  a_ar_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while answer pending");
  a_aw_blocked: assert property (o_s_axi_bvalid |-> !o_s_axi_awready)
    else $error("write taken while response pending");
  c_pkt_end: cover property (o_tx_valid && i_tx_ready && o_tx_word.last);
  c_err: cover property ($rose(o_tx_error_flag));
  c_loaded: cover property ($rose(o_buffer_loaded_flag));
  c_level: cover property (o_status_level_flag);
endmodule
bind tbc_tx_front tbc_tx_front_asserts u_chk (.*);

// *** verif/tbc_mac_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// mac stand-in: collects bytes, reports each packet sent
// ------------------------------------------------------------
module tbc_mac_model (
  input wire logic i_clk, // clock
  input wire logic i_rst, // sync reset
  input wire logic i_stall, // hold off words
  input wire logic i_fail, // report failure
  input wire tbc_pkg::tbc_word_t i_word, // word in
  input wire logic i_valid, // word valid
  output logic o_ready, // word taken
  output logic o_done, // packet sent pulse
  output logic o_fail // packet failed
);
  logic [7:0] rx_q[$]; // bytes received
  int pkts; // packets finished
  int cnt; // cycles until done
  // take words, pulse done a few cycles after the last
  always_ff @(posedge i_clk) begin
    o_ready <= !i_stall && !i_rst;
    o_done <= 1'h0;
    o_fail <= 1'h0;
    if (i_rst) begin
      cnt <= 0;
      pkts <= 0;
    end else begin
      if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 1) begin
        o_done <= 1'h1;
        o_fail <= i_fail;
        pkts <= pkts + 1;
      end
      if (i_valid && o_ready) begin
        for (int k = 0; k < i_word.nbytes; k++) rx_q.push_back(i_word.data[8*k +: 8]);
        if (i_word.last) cnt <= 3;
      end
    end
  end
endmodule

// *** verif/tbc_tx_front_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; \
  if ((s) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tbc_tx_front_tb_top;
  // ------------------------------------------------------------
  // stimulus, design and mac stand-in
  // ------------------------------------------------------------
  logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, arv = 1'h0, stall = 1'h0, failq = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [1:0] bresp, rresp, bres, rres;
  logic awr, wrr, bv, arr, rv, tv, trdy, dn, fl, ef, lf, vf;
  tbc_pkg::tbc_word_t word;
  int errors = 0, samples_checked = 0, npk = 0;
  tbc_tx_front uut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(1'h1), .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(1'h1), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_tx_word(word), .o_tx_valid(tv), .i_tx_ready(trdy), .i_tx_done(dn),
    .i_tx_fail(fl), .o_tx_error_flag(ef), .o_buffer_loaded_flag(lf), .o_status_level_flag(vf));
  tbc_mac_model u_mac (.i_clk(clk), .i_rst(rst), .i_stall(stall), .i_fail(failq), .i_word(word),
    .i_valid(tv), .o_ready(trdy), .o_done(dn), .o_fail(fl));
  initial forever #2.5 clk = ~clk;
  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wrr) wv <= 1'h0;
    end while (!bv);
    bres = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ara <= a;
    arv <= 1'h1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'h0;
    end while (!rv);
    d = rdata;
    rres = rresp;
  endtask
  // one word as low half then high half
  task automatic put(input logic [31:0] w);
    wr(tbc_pkg::ADDR_DATA_PORT, {16'h0, w[15:0]});
    wr(tbc_pkg::ADDR_DATA_PORT, {16'h0, w[31:16]});
  endtask
  function automatic logic [31:0] ca(logic io, logic [1:0] al, logic [4:0] of, logic fs, logic ls, logic [10:0] sz);
    return {io, 5'h0, al, 3'h0, of, 2'h0, fs, ls, 1'h0, sz};
  endfunction
  // buffer: two command words, then payload bytes s, s+1, ...
  task automatic bufw(input logic [31:0] a, input logic [15:0] tag, input logic [10:0] len, input int nw,
                      input logic [7:0] s);
    put(a);
    put({tag, 5'h0, len});
    for (int j = 0; j < nw; j++) put({s + 8'(4*j+3), s + 8'(4*j+2), s + 8'(4*j+1), s + 8'(4*j)});
  endtask
  task automatic chk_bytes(input logic [7:0] s, input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = u_mac.rx_q.size() ? u_mac.rx_q.pop_front() : ~(s + 8'(i));
      `CHK("byte", s + 8'(i), b)
    end
  endtask
  task automatic wait_pkt;
    npk++;
    for (int t = 0; t < 3000 && u_mac.pkts < npk; t++) @(posedge clk);
    // status lands one cycle after done, level flag one cycle later
    repeat (2) @(posedge clk);
    `CHK("pkt", 1'h1, u_mac.pkts >= npk)
  endtask
  task automatic chk_err;
    logic [31:0] d;
    `CHK("err", 1'h1, ef)
    repeat (4) @(posedge clk);
    `CHK("err held", 1'h1, ef)
    wr(tbc_pkg::ADDR_FLAGS, 32'h1);
    rd(tbc_pkg::ADDR_FLAGS, d);
    `CHK("err clr", 1'h0, d[0])
  endtask
  task automatic t_reset;
    logic [31:0] d;
    rd(tbc_pkg::ADDR_CTRL, d);
    `CHK("ctrl", tbc_pkg::CTRL_RESET, d)
    rd(tbc_pkg::ADDR_FLAGS, d);
    `CHK("flags", 32'h0, d)
    rd(tbc_pkg::ADDR_SPACE_INFO, d);
    `CHK("space", 9'h100, d[8:0])
    rd(8'h20, d);
    `CHK("bad rd", tbc_pkg::RESP_SLVERR, rres)
    wr(8'h24, 32'h0);
    `CHK("bad wr", tbc_pkg::RESP_SLVERR, bres)
    wr(tbc_pkg::ADDR_CTRL, 32'h0000_0103);
  endtask
  task automatic t_single;
    logic [31:0] d;
    bufw(ca(1'h0, 2'h3, 5'h02, 1'h1, 1'h1, 11'h006), 16'hA5A5, 11'h006, 2, 8'h10);
    wait_pkt();
    chk_bytes(8'h12, 6);
    rd(tbc_pkg::ADDR_FLAGS, d);
    `CHK("flags", 3'h4, d[2:0])
    `CHK("lvl pin", 1'h1, vf)
    rd(tbc_pkg::ADDR_STATUS, d);
    `CHK("status", {16'hA5A5, 5'h00, 11'h006}, d)
  endtask
  task automatic t_multi;
    logic [31:0] d;
    stall <= 1'h1;
    bufw(ca(1'h0, 2'h1, 5'h03, 1'h1, 1'h0, 11'h005), 16'h1234, 11'h008, 4, 8'h20);
    bufw(ca(1'h1, 2'h2, 5'h01, 1'h0, 1'h1, 11'h003), 16'h1234, 11'h008, 8, 8'h40);
    rd(tbc_pkg::ADDR_SPACE_INFO, d);
    `CHK("space", 1'h1, d[8:0] >= 9'h0F8)
    `CHK("loaded", 1'h1, lf)
    stall <= 1'h0;
    wait_pkt();
    chk_bytes(8'h23, 5);
    chk_bytes(8'h41, 3);
    rd(tbc_pkg::ADDR_STATUS, d);
    `CHK("status", {16'h1234, 5'h00, 11'h008}, d)
    `CHK("no err", 1'h0, ef)
    wr(tbc_pkg::ADDR_FLAGS, 32'h2);
    rd(tbc_pkg::ADDR_FLAGS, d);
    `CHK("loaded clr", 1'h0, d[1])
  endtask
  task automatic t_errors;
    logic [31:0] d;
    bufw(ca(1'h0, 2'h0, 5'h00, 1'h1, 1'h0, 11'h004), 16'h0001, 11'h008, 1, 8'h60);
    bufw(ca(1'h0, 2'h0, 5'h00, 1'h0, 1'h1, 11'h004), 16'h0002, 11'h008, 1, 8'h64);
    wait_pkt();
    chk_err();
    bufw(ca(1'h0, 2'h0, 5'h00, 1'h1, 1'h1, 11'h004), 16'h0003, 11'h005, 1, 8'h70);
    wait_pkt();
    chk_err();
    failq <= 1'h1;
    bufw(ca(1'h0, 2'h0, 5'h00, 1'h1, 1'h1, 11'h004), 16'h0005, 11'h004, 1, 8'h80);
    wait_pkt();
    failq <= 1'h0;
    repeat (3) rd(tbc_pkg::ADDR_STATUS, d);
    `CHK("fail st", 1'h1, d[15])
    stall <= 1'h1;
    bufw(ca(1'h0, 2'h0, 5'h00, 1'h1, 1'h1, 11'h118), 16'h0004, 11'h118, 70, 8'h00);
    `CHK("overfill", 1'h1, ef)
    rst <= 1'h1;
    stall <= 1'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    `CHK("rst err", 1'h0, ef)
  endtask
  task automatic end_sim;
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_single();
    t_multi();
    t_errors();
    end_sim();
  end
endmodule
